// ==== design/cst_i2c_ack.sv ====
module cst_i2c_ack import cst_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = I2C_ADDR
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic en_in,
  output logic ack_oe_out
);
  logic scl_q;
  logic sda_q;
  logic active_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start = scl_in & scl_q & sda_q & ~sda_in;
  assign stop = scl_in & scl_q & ~sda_q & sda_in;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end
  // every byte after start is compared, even inside a foreign transfer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_q <= 1'b0;
      bit_q <= '0;
      sh_q <= '0;
      ack_oe_out <= 1'b0;
    end else if (!en_in || stop) begin
      active_q <= 1'b0;
      bit_q <= '0;
      ack_oe_out <= 1'b0;
    end else if (start) begin
      active_q <= 1'b1;
      bit_q <= '0;
      ack_oe_out <= 1'b0;
    end else if (active_q) begin
      if (scl_rise) begin
        if (bit_q != I2C_ACK_BIT) begin
          sh_q <= {sh_q[6:0], sda_in};
        end
        bit_q <= (bit_q == I2C_ACK_BIT) ? '0 : bit_q + 4'h1;
      end
      if (scl_fall && bit_q == I2C_ACK_BIT && sh_q[7:1] == DEV_ADDR) begin
        ack_oe_out <= 1'b1; // [RULE14]
      end else if (scl_fall && bit_q == '0) begin
        ack_oe_out <= 1'b0;
      end
    end
  end
endmodule

// ==== design/cst_pkg.sv ====
package cst_pkg;
  localparam int CLK_NS = 10;
  localparam int NS_PER_S = 1_000_000_000;
  localparam int NS_PER_MS = 1_000_000;
  localparam int SEC_CYC = NS_PER_S / CLK_NS;
  localparam int RELAX_MS = 32;
  localparam int RELAX_CYC = RELAX_MS * (NS_PER_MS / CLK_NS);
  localparam int SEC_PER_MIN = 60;
  localparam int MIN_PER_HR = 60;
  localparam int PRE_MIN0 = 40;
  localparam int PRE_MIN1 = 60;
  localparam int PRE_MIN2 = 80;
  localparam int TOT_HR0 = 3;
  localparam int TOT_HR1 = 4;
  localparam int TOT_HR2 = 5;
  localparam int SECW = 15;
  localparam int RED_W = 4;
  localparam logic [4:0] RED_SCALE = 5'h10;
  localparam logic [1:0] TSEL_DIS = 2'h3;
  localparam logic [6:0] I2C_ADDR = 7'h5b;
  localparam logic [3:0] I2C_ACK_BIT = 4'h8;
  // register addresses
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_MASK = 8'h01;
  localparam logic [7:0] A_TCFG = 8'h02;
  localparam logic [7:0] A_TMPCFG = 8'h03;
  localparam logic [7:0] A_KEY = 8'h0b;
  // field positions
  localparam int ST_TMR = 0;
  localparam int ST_TMP = 1;
  localparam int ST_TLVL = 2;
  localparam int ST_INR = 3;
  localparam int ST_ACT = 4;
  localparam int TC_PRE = 0;
  localparam int TC_TOT = 2;
  localparam int TC_PEN = 4;
  localparam int TC_TEN = 5;
  localparam int TP_EXIT = 0;
  localparam int TP_RET = 1;
  localparam logic [7:0] RST_VAL = 8'h00;
  // charger state codes
  localparam logic [2:0] CS_PRE = 3'h0;
  localparam logic [2:0] CS_FAST = 3'h1;
  localparam logic [2:0] CS_TOP = 3'h2;
  localparam logic [2:0] CS_EOC = 3'h3;
  localparam logic [2:0] CS_SUSP = 3'h4;
  // serial disable write sequence
  localparam int SEQ_N = 6;
  localparam logic [7:0] SEQ_A [SEQ_N] = '{8'h0b, 8'h02, 8'h03, 8'h0b, 8'h02, 8'h03};
  localparam logic [7:0] SEQ_D [SEQ_N] = '{8'hee, 8'h07, 8'h01, 8'hef, 8'h07, 8'h01};
  typedef enum logic [4:0] {
    SP_IDLE = 5'b0_0001,
    SP_PRE = 5'b0_0010,
    SP_CHG = 5'b0_0100,
    SP_RELAX = 5'b0_1000,
    SP_FAULT = 5'b1_0000
  } cst_sup_t;
endpackage

// ==== design/cst_sync.sv ====
module cst_sync #(
  parameter int W = 1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end
endmodule

// ==== design/cst_top.sv ====
// Function
// [RULE1] precondition period select: 40, 60, 80 minutes, or disabled
// [RULE2] total period select: 3, 4, 5 hours, or disabled
// [RULE3] both periods stretch in proportion to thermal current reduction
// [RULE4] precondition expiry raises timer event when both enables set
// [RULE5] total expiry raises timer event when both enables set
// [RULE6] timer level reads 1 while a timeout has occurred
// [RULE7] timer event flag reads 1 once, cleared by that read
// [RULE8] charge indicator sinks in precondition, fast and top-off; else released
// [RULE9] charging suspended while thermistor is outside hot/cold window
// [RULE10] leaving valid temperature raises event when both enables set
// [RULE11] returning to valid temperature raises event when both enables set
// [RULE12] temperature level reads 1 inside valid range, 0 outside
// [RULE13] temperature event flag reads 1 once, cleared by that read
// [RULE14] serial port acknowledges its address in any byte after start
// [RULE15] six-write key sequence disables serial port, both lines released
// [RULE16] host should keep this part off buses with multi-byte peripherals
// [RULE17] precondition expiry forces the timeout fault state
// [RULE18] total expiry in fast charge forces end-of-charge, restart after relax
// [RULE19] event in same cycle as flag read keeps the flag set
module cst_top import cst_pkg::*; #(
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int RELAX_CYCLES = RELAX_CYC,
  parameter logic [6:0] DEV_ADDR = I2C_ADDR
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic irq_out,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic thermistor_sense_hot_in,
  input wire logic thermistor_sense_cold_in,
  input wire logic [2:0] chg_state_in,
  input wire logic [RED_W-1:0] thermal_current_reduction_in,
  output logic charge_active_indicator_n_out,
  output logic charge_active_indicator_n_oe_out,
  output logic charge_suspend_out,
  output logic force_timeout_fault_out,
  output logic force_eoc_out,
  output logic restart_charge_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic rst_meta_q;
  logic rst_n_q;
  logic [3:0] pin_s;
  logic [7:0] mask_q;
  logic [7:0] tcfg_q;
  logic [7:0] tmpcfg_q;
  logic [7:0] key_q;
  logic tmr_flag_q;
  logic tmp_flag_q;
  logic tlvl_q;
  logic inr_q;
  logic i2c_dis_q;
  logic [2:0] seq_q;
  logic [31:0] pre_cnt_q;
  logic raw_tick;
  logic [4:0] acc_q;
  logic [4:0] acc_sum;
  logic st_tick;
  logic [SECW-1:0] pre_secs_q;
  logic [SECW-1:0] tot_secs_q;
  logic [SECW-1:0] pre_lim;
  logic [SECW-1:0] tot_lim;
  logic pre_exp;
  logic tot_exp;
  logic tmr_ev;
  logic tmp_ev;
  logic inr_now;
  logic rd_status;
  logic charging;
  logic ack_oe;
  logic was_fast_q;
  logic [31:0] relax_q;
  cst_sup_t sp_q;
  cst_sup_t sp_d;

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  cst_sync #(.W(4)) u_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_q),
    .d_in({scl_in, sda_in, thermistor_sense_hot_in, thermistor_sense_cold_in}),
    .q_out(pin_s)
  );

  cst_i2c_ack #(.DEV_ADDR(DEV_ADDR)) u_ack (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_q),
    .scl_in(pin_s[3]),
    .sda_in(pin_s[2]),
    .en_in(~i2c_dis_q),
    .ack_oe_out(ack_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // period limits in seconds
  function automatic logic [SECW-1:0] pre_limit(input logic [1:0] sel);
    case (sel)
      2'h0: pre_limit = SECW'(PRE_MIN0 * SEC_PER_MIN); // [RULE1]
      2'h1: pre_limit = SECW'(PRE_MIN1 * SEC_PER_MIN);
      2'h2: pre_limit = SECW'(PRE_MIN2 * SEC_PER_MIN);
      default: pre_limit = '0;
    endcase
  endfunction

  function automatic logic [SECW-1:0] tot_limit(input logic [1:0] sel);
    case (sel)
      2'h0: tot_limit = SECW'(TOT_HR0 * MIN_PER_HR * SEC_PER_MIN); // [RULE2]
      2'h1: tot_limit = SECW'(TOT_HR1 * MIN_PER_HR * SEC_PER_MIN);
      2'h2: tot_limit = SECW'(TOT_HR2 * MIN_PER_HR * SEC_PER_MIN);
      default: tot_limit = '0;
    endcase
  endfunction

  assign pre_lim = pre_limit(tcfg_q[TC_PRE +: 2]);
  assign tot_lim = tot_limit(tcfg_q[TC_TOT +: 2]);

  ////////////////////////////////////////////////////////////////////////////
  // second ticks, slowed by the current reduction
  assign raw_tick = (pre_cnt_q == 32'(SEC_CYCLES - 1));
  assign acc_sum = acc_q + (RED_SCALE - 5'(thermal_current_reduction_in)); // [RULE3]
  assign st_tick = raw_tick && (acc_sum >= RED_SCALE);

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pre_cnt_q <= '0;
      acc_q <= '0;
    end else begin
      pre_cnt_q <= raw_tick ? '0 : pre_cnt_q + 32'h1;
      if (raw_tick) begin
        acc_q <= st_tick ? acc_sum - RED_SCALE : acc_sum; // [RULE3]
      end
    end
  end

  assign pre_exp = (sp_q == SP_PRE) && st_tick && (tcfg_q[TC_PRE +: 2] != TSEL_DIS)
                   && (pre_secs_q == pre_lim - SECW'(1));
  assign tot_exp = (sp_q == SP_PRE || sp_q == SP_CHG) && st_tick
                   && (tcfg_q[TC_TOT +: 2] != TSEL_DIS) && (tot_secs_q == tot_lim - SECW'(1));

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pre_secs_q <= '0;
      tot_secs_q <= '0;
    end else if (sp_q == SP_IDLE) begin
      pre_secs_q <= '0;
      tot_secs_q <= '0;
    end else if (st_tick) begin
      if (sp_q == SP_PRE) begin
        pre_secs_q <= pre_secs_q + SECW'(1);
      end
      if (sp_q == SP_PRE || sp_q == SP_CHG) begin
        tot_secs_q <= tot_secs_q + SECW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supervision state machine
  assign charging = (chg_state_in == CS_FAST) || (chg_state_in == CS_TOP);

  always_comb begin
    sp_d = sp_q;
    case (sp_q)
      SP_IDLE: begin
        if (chg_state_in == CS_PRE) begin
          sp_d = SP_PRE;
        end else if (charging) begin
          sp_d = SP_CHG;
        end
      end
      SP_PRE: begin
        if (pre_exp) begin
          sp_d = SP_FAULT; // [RULE17]
        end else if (tot_exp) begin
          sp_d = SP_RELAX;
        end else if (charging) begin
          sp_d = SP_CHG;
        end else if (chg_state_in != CS_PRE) begin
          sp_d = SP_IDLE;
        end
      end
      SP_CHG: begin
        if (tot_exp) begin
          sp_d = SP_RELAX; // [RULE18]
        end else if (!charging) begin
          sp_d = SP_IDLE;
        end
      end
      SP_RELAX: begin
        if (relax_q == 32'(RELAX_CYCLES - 1)) begin
          sp_d = SP_IDLE;
        end
      end
      SP_FAULT: begin
        if (chg_state_in == CS_SUSP) begin
          sp_d = SP_IDLE;
        end
      end
      default: sp_d = SP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sp_q <= SP_IDLE;
      relax_q <= '0;
      was_fast_q <= 1'b0;
    end else begin
      sp_q <= sp_d;
      relax_q <= (sp_q == SP_RELAX) ? relax_q + 32'h1 : '0;
      if (sp_q != SP_RELAX) begin
        was_fast_q <= (chg_state_in == CS_FAST);
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      force_timeout_fault_out <= 1'b0;
      force_eoc_out <= 1'b0;
      restart_charge_out <= 1'b0;
    end else begin
      force_timeout_fault_out <= (sp_d == SP_FAULT); // [RULE17]
      force_eoc_out <= (sp_d == SP_RELAX); // [RULE18]
      restart_charge_out <= (sp_q == SP_RELAX) && (sp_d == SP_IDLE) && was_fast_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events and levels
  assign inr_now = ~pin_s[1] & ~pin_s[0];
  assign rd_status = reg_rd_in && (reg_addr_in == A_STATUS);
  assign tmr_ev = mask_q[ST_TMR] && ((pre_exp && tcfg_q[TC_PEN]) // [RULE4]
                  || (tot_exp && tcfg_q[TC_TEN])); // [RULE5]
  assign tmp_ev = mask_q[ST_TMP] && ((inr_q && !inr_now && tmpcfg_q[TP_EXIT]) // [RULE10]
                  || (!inr_q && inr_now && tmpcfg_q[TP_RET])); // [RULE11]

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tmr_flag_q <= 1'b0;
      tmp_flag_q <= 1'b0;
    end else begin
      if (tmr_ev) begin
        tmr_flag_q <= 1'b1; // [RULE19]
      end else if (rd_status) begin
        tmr_flag_q <= 1'b0; // [RULE7]
      end
      if (tmp_ev) begin
        tmp_flag_q <= 1'b1; // [RULE19]
      end else if (rd_status) begin
        tmp_flag_q <= 1'b0; // [RULE13]
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tlvl_q <= 1'b0;
      inr_q <= 1'b1;
    end else begin
      if (pre_exp || tot_exp) begin
        tlvl_q <= 1'b1; // [RULE6]
      end else if (sp_q == SP_IDLE && sp_d == SP_PRE) begin
        tlvl_q <= 1'b0;
      end
      inr_q <= inr_now; // [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, read port and disable key sequence
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= RST_VAL;
      tcfg_q <= RST_VAL;
      tmpcfg_q <= RST_VAL;
      key_q <= RST_VAL;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        A_MASK: mask_q <= reg_wdata_in;
        A_TCFG: tcfg_q <= reg_wdata_in;
        A_TMPCFG: tmpcfg_q <= reg_wdata_in;
        A_KEY: key_q <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata_out <= RST_VAL;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        A_STATUS: reg_rdata_out <= {3'h0, charge_active_indicator_n_oe_out, inr_q, tlvl_q,
                                    tmp_flag_q, tmr_flag_q}; // [RULE7] [RULE13]
        A_MASK: reg_rdata_out <= mask_q;
        A_TCFG: reg_rdata_out <= tcfg_q;
        A_TMPCFG: reg_rdata_out <= tmpcfg_q;
        A_KEY: reg_rdata_out <= key_q;
        default: reg_rdata_out <= RST_VAL;
      endcase
    end else begin
      reg_rdata_out <= RST_VAL;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      seq_q <= '0;
      i2c_dis_q <= 1'b0;
    end else if (reg_wr_in && !i2c_dis_q) begin
      if (reg_addr_in == SEQ_A[seq_q] && reg_wdata_in == SEQ_D[seq_q]) begin
        seq_q <= seq_q + 3'h1;
        i2c_dis_q <= (seq_q == 3'(SEQ_N - 1)); // [RULE15]
      end else if (reg_addr_in == SEQ_A[0] && reg_wdata_in == SEQ_D[0]) begin
        seq_q <= 3'h1;
      end else begin
        seq_q <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pins and interrupt
  always_ff @(posedge sys_clk_in or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      scl_oe_out <= 1'b0;
      sda_oe_out <= 1'b0;
      charge_active_indicator_n_out <= 1'b0;
      charge_active_indicator_n_oe_out <= 1'b0;
      charge_suspend_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      scl_oe_out <= 1'b0;
      sda_oe_out <= ack_oe && !i2c_dis_q; // [RULE14] [RULE15]
      charge_active_indicator_n_oe_out <= (chg_state_in == CS_PRE) || charging; // [RULE8]
      charge_suspend_out <= !inr_now; // [RULE9]
      irq_out <= |({tmp_flag_q, tmr_flag_q} & mask_q[ST_TMP:ST_TMR]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_q);

  property p_pre_lim;
    pre_exp |-> tcfg_q[TC_PRE +: 2] != TSEL_DIS && int'(pre_secs_q) + 1 == SEC_PER_MIN
      * (tcfg_q[TC_PRE +: 2] == 2'h0 ? PRE_MIN0 : tcfg_q[TC_PRE +: 2] == 2'h1 ? PRE_MIN1 : PRE_MIN2);
  endproperty
  a_pre_lim: assert property (p_pre_lim) else $error("bad precondition limit"); // [RULE1]
  property p_tot_dis;
    tcfg_q[TC_TOT +: 2] == TSEL_DIS |-> !tot_exp;
  endproperty
  a_tot_dis: assert property (p_tot_dis) else $error("disabled total timer expired"); // [RULE2]
  property p_stretch;
    raw_tick && thermal_current_reduction_in == '0 |-> st_tick;
  endproperty
  a_stretch: assert property (p_stretch) else $error("unreduced tick lost"); // [RULE3]
  property p_pre_ev;
    pre_exp && tcfg_q[TC_PEN] && mask_q[ST_TMR] |=> tmr_flag_q;
  endproperty
  a_pre_ev: assert property (p_pre_ev) else $error("precondition event missed"); // [RULE4]
  property p_tlvl;
    pre_exp || tot_exp |=> tlvl_q;
  endproperty
  a_tlvl: assert property (p_tlvl) else $error("timer level not shown"); // [RULE6]
  property p_rd_clr;
    rd_status && tmr_flag_q && !tmr_ev |=> reg_rdata_out[ST_TMR] && !tmr_flag_q;
  endproperty
  a_rd_clr: assert property (p_rd_clr) else $error("timer flag read-clear wrong"); // [RULE7]
  property p_ind;
    chg_state_in == CS_EOC |=> !charge_active_indicator_n_oe_out;
  endproperty
  a_ind: assert property (p_ind) else $error("indicator driven at end of charge"); // [RULE8]
  property p_susp;
    pin_s[1] |=> charge_suspend_out;
  endproperty
  a_susp: assert property (p_susp) else $error("no suspend when out of range"); // [RULE9]
  property p_keep;
    tmp_ev && rd_status |=> tmp_flag_q;
  endproperty
  a_keep: assert property (p_keep) else $error("temperature event lost on read"); // [RULE19]
  property p_dis;
    i2c_dis_q |=> !sda_oe_out && !scl_oe_out;
  endproperty
  a_dis: assert property (p_dis) else $error("serial line driven after disable"); // [RULE15]
  property p_fault;
    pre_exp |=> sp_q == SP_FAULT && force_timeout_fault_out;
  endproperty
  a_fault: assert property (p_fault) else $error("no timeout fault"); // [RULE17]
endmodule

// ==== tb/cst_i2c_host.sv ====
module cst_i2c_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // sole master on this port, no multi-byte peripheral beside it
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // quarter of a 160 ns serial period
  task automatic qtr();
    repeat (4) @(posedge clk_in);
  endtask
  task automatic start_cond();
    sda_out <= 1'b0;
    qtr();
    scl_out <= 1'b0;
    qtr();
  endtask
  task automatic stop_cond();
    sda_out <= 1'b0;
    qtr();
    scl_out <= 1'b1;
    qtr();
    sda_out <= 1'b1;
    qtr();
  endtask
  // msb first, data changes only while clock is low, then ack slot
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_out <= b[i];
      qtr();
      scl_out <= 1'b1;
      qtr();
      qtr();
      scl_out <= 1'b0;
      qtr();
    end
    sda_out <= 1'b1;
    qtr();
    scl_out <= 1'b1;
    qtr();
    ack = sda_in;
    qtr();
    scl_out <= 1'b0;
    qtr();
  endtask
endmodule

// ==== tb/tb_cst_top.sv ====
module tb_cst_top import cst_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, wr, rd, hot, cold, h_scl, h_sda;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] chg;
  logic [RED_W-1:0] red;
  logic irq, scl_o, scl_oe, sda_o, sda_oe, ind_n, ind_oe, susp, fault, eoc, restart;
  wire logic scl_w, sda_w;
  int n_errors = 0;
  int check_count = 0;
  // open-drain wires with pull-ups
  assign scl_w = h_scl & ~(scl_oe & ~scl_o);
  assign sda_w = h_sda & ~(sda_oe & ~sda_o);
  cst_top #(.SEC_CYCLES(2), .RELAX_CYCLES(20)) i_dut (
    .sys_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .irq_out(irq),
    .scl_in(scl_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .thermistor_sense_hot_in(hot), .thermistor_sense_cold_in(cold),
    .chg_state_in(chg), .thermal_current_reduction_in(red),
    .charge_active_indicator_n_out(ind_n), .charge_active_indicator_n_oe_out(ind_oe),
    .charge_suspend_out(susp), .force_timeout_fault_out(fault),
    .force_eoc_out(eoc), .restart_charge_out(restart));
  cst_i2c_host i_host (.clk_in(clk), .sda_in(sda_w), .scl_out(h_scl), .sda_out(h_sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, rdata, exp);
  endtask
  // bounded wait for an output level, returns cycles taken
  task automatic wait_on(input int sel, input logic lvl, input int lim, output int n);
    logic v;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      case (sel)
        0: v = fault;
        1: v = eoc;
        2: v = restart;
        3: v = irq;
        default: v = susp;
      endcase
    end while (v !== lvl && n < lim);
    if (v !== lvl) begin
      n_errors++;
      $display("MISMATCH wait_%0d exp %b seen %b", sel, lvl, v);
      end_of_test();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd_reg(A_STATUS, 8'h08, "status_rst");
    wr_reg(A_STATUS, 8'hff);
    wr_reg(8'h40, 8'h5a);
    rd_reg(A_STATUS, 8'h08, "status_ro");
    rd_reg(8'h40, 8'h00, "unmapped");
    rd_reg(A_TCFG, 8'h00, "tcfg_rst");
    wr_reg(A_MASK, 8'h03);
    rd_reg(A_MASK, 8'h03, "mask");
    $display("test regs done");
  endtask
  task automatic t_ind();
    for (int s = 0; s < 8; s++) begin
      @(posedge clk);
      chg <= s[2:0];
      repeat (2) @(posedge clk);
      #1;
      chk("ind_oe", ind_oe, s < 3);
      chk("ind_n", ind_n, 0);
    end
    chg <= 3'h3;
    $display("test indicator done");
  endtask
  task automatic t_temp();
    int n;
    wr_reg(A_TMPCFG, 8'h01);
    hot <= 1'b1;
    wait_on(3, 1'b1, 20, n);
    chk("susp", susp, 1);
    rd_reg(A_STATUS, 8'h02, "exit_evt");
    rd_reg(A_STATUS, 8'h00, "exit_clr");
    chk("irq_clr", irq, 0);
    hot <= 1'b0;
    wait_on(4, 1'b0, 20, n);
    rd_reg(A_STATUS, 8'h08, "ret_off");
    wr_reg(A_TMPCFG, 8'h02);
    cold <= 1'b1;
    wait_on(4, 1'b1, 20, n);
    rd_reg(A_STATUS, 8'h00, "exit_off");
    cold <= 1'b0;
    wait_on(3, 1'b1, 20, n);
    rd_reg(A_STATUS, 8'h0a, "ret_evt");
    // exit event lands in the very cycle of a status read
    wr_reg(A_TMPCFG, 8'h01);
    hot <= 1'b1;
    @(posedge clk);
    rd_reg(A_STATUS, 8'h08, "keep_rd");
    rd_reg(A_STATUS, 8'h02, "keep_evt");
    hot <= 1'b0;
    $display("test temperature done");
  endtask
  task automatic t_timer();
    int n;
    wr_reg(A_TCFG, 8'h30);
    red <= 4'h8;
    chg <= 3'h0;
    // 40 min at 2 cycles a second, doubled by half current
    wait_on(0, 1'b1, 12000, n);
    chk("pre_len", n inside {[9500:9700]}, 1);
    wait_on(3, 1'b1, 4, n);
    chk("irq_pre", irq, 1);
    rd_reg(A_STATUS, 8'h1d, "pre_evt");
    rd_reg(A_STATUS, 8'h1c, "pre_clr");
    chg <= 3'h4;
    red <= 4'h0;
    wait_on(0, 1'b0, 20, n);
    chg <= 3'h1;
    // 3 h at 2 cycles a second
    wait_on(1, 1'b1, 23000, n);
    chk("tot_len", n inside {[21550:21650]}, 1);
    wait_on(2, 1'b1, 40, n);
    chk("relax_len", n inside {[18:22]}, 1);
    rd_reg(A_STATUS, 8'h1d, "tot_evt");
    chg <= 3'h3;
    $display("test timer done");
  endtask
  task automatic t_sel();
    int n;
    int e;
    for (int s = 1; s < 3; s++) begin
      e = 2 * SEC_PER_MIN * (s == 1 ? PRE_MIN1 : PRE_MIN2);
      wr_reg(A_TCFG, 8'(s));
      chg <= 3'h0;
      wait_on(0, 1'b1, 10000, n);
      chk("pre_sel", n inside {[e - 10:e + 10]}, 1);
      chg <= 3'h4;
      wait_on(0, 1'b0, 20, n);
    end
    // both timers disabled: no fault even past the longest precondition period
    wr_reg(A_TCFG, 8'h0f);
    chg <= 3'h0;
    repeat (10000) @(posedge clk);
    #1;
    chk("pre_dis", fault, 0);
    chk("tot_dis", eoc, 0);
    chg <= 3'h3;
    $display("test select done");
  endtask
  task automatic t_i2c();
    logic a;
    i_host.start_cond();
    i_host.send_byte(8'h20, a);
    chk("ack_other", a, 1);
    i_host.send_byte({I2C_ADDR, 1'b0}, a);
    chk("ack_inside", a, 0);
    i_host.stop_cond();
    wr_reg(8'h0b, 8'hee);
    wr_reg(8'h02, 8'h07);
    wr_reg(8'h03, 8'h01);
    wr_reg(8'h0b, 8'hef);
    wr_reg(8'h02, 8'h07);
    wr_reg(8'h03, 8'h01);
    i_host.start_cond();
    i_host.send_byte({I2C_ADDR, 1'b0}, a);
    chk("ack_off", a, 1);
    i_host.stop_cond();
    #1;
    chk("scl_oe", scl_oe, 0);
    chk("sda_oe", sda_oe, 0);
    $display("test serial done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    hot = 1'b0;
    cold = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    chg = 3'h3;
    red = 4'h0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_ind();
    t_temp();
    t_timer();
    t_sel();
    t_i2c();
    end_of_test();
  end
endmodule
